// [rtl/adc_conversion_sequencer.sv]
// Conversion sequencer for a successive-approximation converter core.
// Assumes a register master on CLK_SYS and a core that holds its result
// on CORE_RESULT when a conversion ends; trigger inputs are synchronous.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int RESULT_W = 10,
   parameter int TRIG_W = 7
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [TRIG_W-1:0] TRIG_IN,
   input wire logic [RESULT_W-1:0] CORE_RESULT,
   output logic SAMPLE_HOLD,
   output logic CONV_ACTIVE,
   output logic [5:0] CONV_CHANNEL,
   output logic CONV_DIFF,
   output logic IRQ
);

   // The byte layout and the trigger decode serve only these widths
   if (RESULT_W != 10) begin : g_result_w_check
      $error("RESULT_W must be 10");
   end
   if (TRIG_W != 7) begin : g_trig_w_check
      $error("TRIG_W must be 7");
   end

   ctrl_a_t ca_reg, ca_next;
   logic [2:0] tsel_reg, tsel_next;
   mux_t mux_reg, mux_next;
   mux_t act_reg, act_next;
   logic [6:0] presc_reg, presc_next;
   logic half_rate_conv_clock_reg, half_rate_conv_clock_next;
   seq_state_t state_reg, state_next;
   logic [5:0] halves_reg, halves_next;
   logic [5:0] sh_at_reg, sh_at_next;
   logic [5:0] end_at_reg, end_at_next;
   logic first_reg, first_next;
   logic trig_prev_reg, trig_prev_next;
   logic [1:0] sync_reg, sync_next;
   logic lock_reg, lock_next;
   logic [9:0] result_reg, result_next;
   logic [7:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic sh_reg, sh_next;
   logic active_reg, active_next;

   logic [2:0] shift;
   logic [6:0] presc_top;
   logic [6:0] presc_mid;
   logic presc_clear;
   logic rise_tick;
   logic fall_tick;
   logic trig_lvl;
   logic trig_edge;
   logic free_run;
   logic [7:0] res_lo;
   logic [7:0] res_hi;

   // Divider terminal counts: selects 0 and 1 both divide by two
   always_comb begin
      shift = (ca_reg.clock_divider_select == 3'h0) ? 3'h1 : ca_reg.clock_divider_select;
      presc_top = 7'((8'h01 << shift) - 8'h01);
      presc_mid = presc_top >> 1;
      rise_tick = ca_reg.converter_enable && (presc_reg == presc_top);
      fall_tick = ca_reg.converter_enable && (presc_reg == presc_mid);
   end

   // Trigger selection and edge detection on the chosen source
   always_comb begin
      free_run = ca_reg.auto_trigger_enable && (tsel_reg == TSEL_FREE_RUN);
      if (tsel_reg == TSEL_FREE_RUN) begin
         trig_lvl = ca_reg.conv_done_flag;
      end else begin
         trig_lvl = TRIG_IN[3'(tsel_reg - 3'h1)];
      end
      trig_edge = trig_lvl && !trig_prev_reg;
   end

   // Result bytes in the selected justification
   always_comb begin
      if (mux_reg.left_justify_result) begin
         res_hi = result_reg[9:2];
         res_lo = {result_reg[1:0], 6'h00};
      end else begin
         res_hi = {6'h00, result_reg[9:8]};
         res_lo = result_reg[7:0];
      end
   end

   // Register port, prescaler and conversion sequencer
   always_comb begin
      ca_next = ca_reg;
      tsel_next = tsel_reg;
      mux_next = mux_reg;
      act_next = act_reg;
      half_rate_conv_clock_next = half_rate_conv_clock_reg;
      state_next = state_reg;
      halves_next = halves_reg;
      sh_at_next = sh_at_reg;
      end_at_next = end_at_reg;
      first_next = first_reg;
      sync_next = sync_reg;
      lock_next = lock_reg;
      result_next = result_reg;
      rdata_next = 8'h00;
      sh_next = 1'b0;
      presc_clear = 1'b0;
      trig_prev_next = trig_lvl;

      // Software writes; a one on the done bit clears it
      if (WR) begin
         case (ADDR)
            ADDR_CTRL_A: begin
               ca_next.converter_enable = WDATA[7];
               ca_next.conv_start_flag = ca_reg.conv_start_flag | (WDATA[6] & WDATA[7]);
               ca_next.auto_trigger_enable = WDATA[5];
               ca_next.conv_done_flag = ca_reg.conv_done_flag & ~WDATA[4];
               ca_next.irq_enable = WDATA[3];
               ca_next.clock_divider_select = WDATA[2:0];
            end
            ADDR_CTRL_B: begin
               tsel_next = WDATA[2:0];
            end
            ADDR_MUX: begin
               mux_next = WDATA;
            end
            default: begin
            end
         endcase
      end

      // Software reads; low byte locks the result, high byte unlocks it
      if (RD) begin
         case (ADDR)
            ADDR_CTRL_A: begin
               rdata_next = ca_reg;
               rdata_next[6] = ca_reg.conv_start_flag | (state_reg != ST_IDLE);
            end
            ADDR_CTRL_B: begin
               rdata_next = {5'h00, tsel_reg};
            end
            ADDR_MUX: begin
               rdata_next = mux_reg;
            end
            ADDR_RES_LO: begin
               rdata_next = res_lo;
               lock_next = 1'b1;
            end
            ADDR_RES_HI: begin
               rdata_next = res_hi;
               lock_next = 1'b0;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end

      // Sequencer
      case (state_reg)
         ST_IDLE: begin
            if (ca_reg.converter_enable) begin
               act_next = mux_reg;
            end
            if (ca_reg.conv_start_flag) begin
               state_next = ST_WAIT_EDGE;
            end else if (ca_reg.auto_trigger_enable && !free_run && trig_edge) begin
               state_next = ST_SYNC;
               sync_next = 2'h0;
            end
         end
         ST_WAIT_EDGE: begin
            if (rise_tick) begin
               state_next = ST_CONV;
               halves_next = 6'h00;
               if (first_reg) begin
                  sh_at_next = SH_FIRST;
                  end_at_next = END_FIRST;
               end else if (act_reg.differential && half_rate_conv_clock_reg) begin
                  sh_at_next = SH_DIFF_SLOW;
                  end_at_next = END_DIFF_SLOW;
               end else begin
                  sh_at_next = SH_NORMAL;
                  end_at_next = END_NORMAL;
               end
            end
         end
         ST_SYNC: begin
            sync_next = 2'(sync_reg + 2'h1);
            if (sync_reg == SYNC_LAST) begin
               presc_clear = 1'b1;
               state_next = ST_CONV;
               halves_next = 6'h00;
               sh_at_next = first_reg ? SH_FIRST : SH_AUTO;
               end_at_next = first_reg ? END_FIRST : END_AUTO;
            end
         end
         ST_CONV: begin
            if (rise_tick || fall_tick) begin
               halves_next = 6'(halves_reg + 6'h01);
               if (halves_next == sh_at_reg) begin
                  sh_next = 1'b1;
               end
               if (halves_next == end_at_reg) begin
                  ca_next.conv_done_flag = 1'b1;
                  first_next = 1'b0;
                  if (!lock_reg) begin
                     result_next = CORE_RESULT;
                  end
                  if (free_run) begin
                     // Restart at once, start flag left high
                     halves_next = 6'h00;
                     act_next = mux_reg;
                     if (mux_reg.differential) begin
                        sh_at_next = SH_DIFF_SLOW;
                        end_at_next = END_DIFF_SLOW;
                     end else begin
                        sh_at_next = SH_NORMAL;
                        end_at_next = END_NORMAL;
                     end
                  end else begin
                     ca_next.conv_start_flag = 1'b0;
                     state_next = ST_IDLE;
                  end
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      // Half-rate clock follows converter clock rising edges
      if (rise_tick) begin
         half_rate_conv_clock_next = ~half_rate_conv_clock_reg;
      end

      // Prescaler runs with enable and restarts on a trigger
      if (!ca_reg.converter_enable || presc_clear) begin
         presc_next = 7'h00;
      end else if (presc_reg == presc_top) begin
         presc_next = 7'h00;
      end else begin
         presc_next = 7'(presc_reg + 7'h01);
      end

      // Disabled converter drops any conversion and rearms the long first one
      if (!ca_reg.converter_enable) begin
         state_next = ST_IDLE;
         ca_next.conv_start_flag = ca_next.conv_start_flag & ca_next.converter_enable;
         first_next = 1'b1;
         half_rate_conv_clock_next = 1'b0;
         sh_next = 1'b0;
      end

      active_next = (state_next == ST_CONV);
      irq_next = ca_next.conv_done_flag & ca_next.irq_enable;
   end

   // State registers
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         ca_reg <= CTRL_A_RST;
         tsel_reg <= CTRL_B_RST;
         mux_reg <= MUX_RST;
         act_reg <= MUX_RST;
         presc_reg <= 7'h00;
         half_rate_conv_clock_reg <= 1'b0;
         state_reg <= ST_IDLE;
         halves_reg <= 6'h00;
         sh_at_reg <= 6'h00;
         end_at_reg <= 6'h00;
         first_reg <= 1'b1;
         trig_prev_reg <= 1'b0;
         sync_reg <= 2'h0;
         lock_reg <= 1'b0;
         result_reg <= 10'h000;
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
         sh_reg <= 1'b0;
         active_reg <= 1'b0;
      end else begin
         ca_reg <= ca_next;
         tsel_reg <= tsel_next;
         mux_reg <= mux_next;
         act_reg <= act_next;
         presc_reg <= presc_next;
         half_rate_conv_clock_reg <= half_rate_conv_clock_next;
         state_reg <= state_next;
         halves_reg <= halves_next;
         sh_at_reg <= sh_at_next;
         end_at_reg <= end_at_next;
         first_reg <= first_next;
         trig_prev_reg <= trig_prev_next;
         sync_reg <= sync_next;
         lock_reg <= lock_next;
         result_reg <= result_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         sh_reg <= sh_next;
         active_reg <= active_next;
      end
   end

   // Outputs straight from flip-flops
   assign RDATA = rdata_reg;
   assign IRQ = irq_reg;
   assign SAMPLE_HOLD = sh_reg;
   assign CONV_ACTIVE = active_reg;
   assign CONV_CHANNEL = act_reg.channel;
   assign CONV_DIFF = act_reg.differential;

endmodule

// [rtl/adc_seq_pkg.sv]
// Shared constants and types for the conversion sequencer.
// Assumes an 8-bit register port and a 3-bit register address.
package adc_seq_pkg;

   // Register addresses
   localparam logic [2:0] ADDR_CTRL_A = 3'h0;
   localparam logic [2:0] ADDR_CTRL_B = 3'h1;
   localparam logic [2:0] ADDR_MUX = 3'h2;
   localparam logic [2:0] ADDR_RES_LO = 3'h3;
   localparam logic [2:0] ADDR_RES_HI = 3'h4;

   // Reset values
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [2:0] CTRL_B_RST = 3'h0;
   localparam logic [7:0] MUX_RST = 8'h00;

   // Trigger source code that selects free running
   localparam logic [2:0] TSEL_FREE_RUN = 3'h0;

   // Conversion lengths in converter clock cycles
   localparam int CONV_CYC_NORMAL = 13;
   localparam int CONV_CYC_FIRST = 25;
   localparam int CONV_CYC_DIFF_SLOW = 14;
   // Sample-and-hold and auto-trigger figures in half converter cycles
   localparam int SH_HALF_NORMAL = 3;
   localparam int SH_HALF_FIRST = 27;
   localparam int SH_HALF_DIFF_SLOW = 5;
   localparam int SH_HALF_AUTO = 4;
   localparam int CONV_HALF_AUTO = 27;
   // Trigger synchronisation in CPU clock cycles
   localparam int SYNC_CPU_CYCLES = 3;

   // Counts in half converter cycles and, for SYNC_LAST, CPU clock cycles, as the sequencer uses them
   localparam logic [5:0] END_NORMAL = 6'(2 * CONV_CYC_NORMAL);
   localparam logic [5:0] END_FIRST = 6'(2 * CONV_CYC_FIRST);
   localparam logic [5:0] END_DIFF_SLOW = 6'(2 * CONV_CYC_DIFF_SLOW);
   localparam logic [5:0] END_AUTO = 6'(CONV_HALF_AUTO);
   localparam logic [5:0] SH_NORMAL = 6'(SH_HALF_NORMAL);
   localparam logic [5:0] SH_FIRST = 6'(SH_HALF_FIRST);
   localparam logic [5:0] SH_DIFF_SLOW = 6'(SH_HALF_DIFF_SLOW);
   localparam logic [5:0] SH_AUTO = 6'(SH_HALF_AUTO);
   localparam logic [1:0] SYNC_LAST = 2'(SYNC_CPU_CYCLES - 1);

   // Control register A, bit 7 down to bit 0
   typedef struct packed {
      logic converter_enable;
      logic conv_start_flag;
      logic auto_trigger_enable;
      logic conv_done_flag;
      logic irq_enable;
      logic [2:0] clock_divider_select;
   } ctrl_a_t;

   // Channel select register, bit 7 down to bit 0
   typedef struct packed {
      logic differential;
      logic left_justify_result;
      logic [5:0] channel;
   } mux_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT_EDGE = 2'b01,
      ST_SYNC = 2'b10,
      ST_CONV = 2'b11
   } seq_state_t;

endpackage

// [tb/adc_seq_asserts.sv]
// Concurrent checks on the conversion sequencer ports.
// Assumes the control register layout of adc_seq_pkg and a bind from the bench.
`timescale 1ns/1ps

module adc_seq_asserts
   import adc_seq_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic SAMPLE_HOLD,
   input wire logic CONV_ACTIVE,
   input wire logic [5:0] CONV_CHANNEL,
   input wire logic CONV_DIFF,
   input wire logic IRQ
);
   logic ctl_wr;
   logic en_reg;
   logic ien_reg;
   logic sel1_reg;
   logic auto_reg;
   logic abort_reg;
   logic [1:0] off_cnt;
   logic [7:0] len_cnt;

   assign ctl_wr = WR && ADDR == ADDR_CTRL_A;

   // Shadow of the written control bits, disabled time and conversion length
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         en_reg <= 1'b0;
         ien_reg <= 1'b0;
         sel1_reg <= 1'b0;
         auto_reg <= 1'b0;
         abort_reg <= 1'b0;
         off_cnt <= 2'h0;
         len_cnt <= 8'h00;
      end else begin
         if (ctl_wr) begin
            en_reg <= WDATA[7];
            auto_reg <= WDATA[5];
            ien_reg <= WDATA[3];
            sel1_reg <= WDATA[2:0] == 3'h1;
         end
         if (en_reg) off_cnt <= 2'h0;
         else if (off_cnt != 2'h3) off_cnt <= off_cnt + 2'h1;
         if (!CONV_ACTIVE) len_cnt <= 8'h00;
         else if (len_cnt != 8'hFF) len_cnt <= len_cnt + 8'h01;
         if (!CONV_ACTIVE) abort_reg <= 1'b0;
         else if (ctl_wr && !WDATA[7]) abort_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   sequence s_off;
      ctl_wr && !WDATA[7];
   endsequence

   sequence s_end;
      $fell(CONV_ACTIVE) && sel1_reg && !auto_reg && !abort_reg;
   endsequence

   a_sh_in_conv: assert property (SAMPLE_HOLD |-> CONV_ACTIVE)
      else $error("sample pulse outside a conversion");
   a_sh_place: assert property (SAMPLE_HOLD && sel1_reg && !auto_reg |->
      len_cnt inside {[8'd1:8'd6], [8'd24:8'd28]})
      else $error("sample pulse at wrong point of conversion");
   a_conv_len: assert property (s_end |->
      len_cnt inside {[8'd25:8'd29], [8'd49:8'd51]})
      else $error("conversion length wrong");
   a_irq_at_end: assert property (s_end ##0 ien_reg |-> ##[0:3] IRQ)
      else $error("no interrupt after conversion end");
   a_irq_masked: assert property (!ien_reg |-> !IRQ)
      else $error("interrupt while its enable is clear");
   a_off_idle: assert property (off_cnt == 2'h3 |-> !CONV_ACTIVE)
      else $error("converting while disabled");
   a_abort_idle: assert property (s_off |-> ##[1:4] !CONV_ACTIVE)
      else $error("disable did not stop the conversion");
   a_chan_hold: assert property (SAMPLE_HOLD |=> $stable({CONV_DIFF, CONV_CHANNEL})[*8])
      else $error("channel changed during conversion");
endmodule

// [tb/adc_core_model.sv]
// Behavioural analog core and trigger flag sources facing the sequencer.
// Assumes pulses on fire and clr come from the bench one cycle long.
`timescale 1ns/1ps

module adc_core_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sample,
   input wire logic [9:0] analog,
   input wire logic [6:0] fire,
   input wire logic [6:0] clr,
   output logic [9:0] result,
   output logic [6:0] trig
);
   // Hold the input at the sample instant; flags set unmasked, cleared by software
   always_ff @(posedge clk) begin
      if (!nrst) begin
         result <= 10'h2AA;
         trig <= 7'h00;
      end else begin
         if (sample) result <= analog;
         trig <= (trig | fire) & ~clr;
      end
   end
endmodule

// [tb/adc_conversion_sequencer_test.sv]
// Self-checking bench for the conversion sequencer with its core model.
// Assumes divider code 1 for most runs and trigger select 2 on flag bit 1.
`timescale 1ns/1ps

module adc_conversion_sequencer_test import adc_seq_pkg::*;;
   typedef struct {
      logic [7:0] c;
      logic [7:0] m;
      logic [9:0] a;
      logic [7:0] lo;
      logic [7:0] hi;
      int len;
   } row_t;
   logic clk_sys, nrst, wr, rd, sample_hold, conv_active, conv_diff, irq;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [6:0] trig_in, fire, clr;
   logic [9:0] core_result, analog;
   logic [5:0] conv_channel;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   // Rows: control, channel, level, bytes, length; quick divider codes keep runs short
   row_t rows [4] = '{'{8'hC9, 8'h05, 10'h2A5, 8'hA5, 8'h02, 50},
      '{8'hC9, 8'h43, 10'h2A5, 8'h40, 8'hA9, 26}, '{8'hCA, 8'h3F, 10'h3FF, 8'hFF, 8'h03, 52},
      '{8'hC9, 8'h3A, 10'h100, 8'h00, 8'h01, 26}};

   adc_conversion_sequencer i_adc_conversion_sequencer (.CLK_SYS(clk_sys), .NRST(nrst),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TRIG_IN(trig_in),
      .CORE_RESULT(core_result), .SAMPLE_HOLD(sample_hold), .CONV_ACTIVE(conv_active),
      .CONV_CHANNEL(conv_channel), .CONV_DIFF(conv_diff), .IRQ(irq));
   adc_core_model i_adc_core_model (.clk(clk_sys), .nrst(nrst), .sample(sample_hold),
      .analog(analog), .fire(fire), .clr(clr), .result(core_result), .trig(trig_in));

   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   // Cycles until the next sample pulse, 120 when none comes
   task automatic wsh(output int k);
      k = 0;
      do begin
         step;
         k++;
      end while (sample_hold !== 1'b1 && k < 120);
   endtask
   task automatic wend(output int k);
      k = 0;
      while (conv_active === 1'b1 && k < 200) begin
         step;
         k++;
      end
   endtask
   task automatic go(input logic [7:0] c, input logic [7:0] m, input logic [9:0] a);
      int k;
      analog <= a;
      wr_reg(ADDR_MUX, m);
      wr_reg(ADDR_CTRL_A, c);
      k = 0;
      do step; while (conv_active !== 1'b1 && ++k < 8);
      chk("start", 16'h1, 16'(conv_active));
   endtask
   task automatic trg(input logic f);
      @(posedge clk_sys);
      if (f) fire <= 7'h02;
      else clr <= 7'h02;
      @(posedge clk_sys);
      fire <= 7'h00;
      clr <= 7'h00;
   endtask
   task automatic free_run(input logic [7:0] m, input int gap);
      int k;
      wr_reg(ADDR_CTRL_A, 8'h00); // Enable off, then on again below
      wr_reg(ADDR_CTRL_B, 8'h00);
      wr_reg(ADDR_MUX, m);
      wr_reg(ADDR_CTRL_A, 8'hE9);
      wsh(k);
      wsh(k);
      wsh(k);
      chk("gap", 16'(gap), 16'(k));
      wsh(k);
      chk("gap", 16'(gap), 16'(k));
      rd_reg(ADDR_CTRL_A, d);
      chk("run flags", 16'h3, 16'({d[6], d[4]}));
      chk("diff", 16'(m[7]), 16'(conv_diff));
      wr_reg(ADDR_CTRL_A, 8'h00);
      wsh(k);
      chk("stopped", 16'd120, 16'(k));
      $display("free run %h done", m);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude;
      end
   end

   initial begin
      {nrst, wr, rd, addr, wdata, fire, clr, analog} = '0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      step;
      chk("outs", 16'h0, 16'({sample_hold, conv_active, conv_channel, conv_diff, irq}));
      rd_reg(ADDR_CTRL_A, d);
      chk("ctrl rst", 16'(CTRL_A_RST), 16'(d));
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         go(rows[i].c, rows[i].m, rows[i].a);
         chk("chan", 16'(rows[i].m[5:0]), 16'(conv_channel));
         wend(n);
         chk("len", 16'h1, 16'(n >= rows[i].len - 1 && n <= rows[i].len + 1));
         rd_reg(ADDR_CTRL_A, d);
         chk("flags", 16'h1, 16'({d[6], d[4]}));
         rd_reg(ADDR_RES_LO, d);
         chk("lo", 16'(rows[i].lo), 16'(d));
         rd_reg(ADDR_RES_HI, d);
         chk("hi", 16'(rows[i].hi), 16'(d));
         chk("irq", 16'h1, 16'(irq));
         wr_reg(ADDR_CTRL_A, (rows[i].c & 8'hBF) | 8'h10);
         $display("row %0d done", i);
      end
      // Result lock with a channel change in mid conversion
      go(8'hC9, 8'h02, 10'h111);
      wend(n);
      rd_reg(ADDR_RES_LO, d);
      wr_reg(ADDR_CTRL_A, 8'h99);
      go(8'hC9, 8'h02, 10'h3C3);
      wsh(n);
      wr_reg(ADDR_MUX, 8'h07);
      step;
      chk("old chan", 16'h2, 16'(conv_channel));
      wend(n);
      step;
      step;
      chk("irq lost", 16'h1, 16'(irq));
      rd_reg(ADDR_RES_HI, d);
      chk("held hi", 16'h1, 16'(d));
      rd_reg(ADDR_RES_LO, d);
      chk("held lo", 16'h11, 16'(d));
      chk("new chan", 16'h7, 16'(conv_channel));
      rd_reg(ADDR_RES_HI, d);
      $display("lock test done");
      // Trigger edges start, mid-conversion and held triggers do not
      wr_reg(ADDR_CTRL_B, 8'h02);
      wr_reg(ADDR_CTRL_A, 8'hB9);
      trg(1'b1);
      wsh(n);
      chk("trig lat", 16'h1, 16'(n > 4 && n < 14));
      rd_reg(ADDR_CTRL_A, d);
      chk("busy", 16'h1, 16'(d[6]));
      trg(1'b0);
      trg(1'b1);
      wend(n);
      wsh(n);
      chk("no restart", 16'd120, 16'(n));
      trg(1'b0);
      trg(1'b1);
      wsh(n);
      chk("retrig", 16'h1, 16'(n < 14));
      wend(n);
      wr_reg(ADDR_CTRL_A, 8'hF9);
      wsh(n);
      chk("auto start", 16'h1, 16'(n < 14));
      wend(n);
      $display("trigger test done");
      free_run(8'h04, 26);
      free_run(8'h84, 28);
      wr_reg(ADDR_CTRL_A, 8'h40);
      wsh(n);
      chk("off start", 16'd120, 16'(n));
      $display("disabled start test done");
      conclude;
   end
endmodule

bind adc_conversion_sequencer adc_seq_asserts i_adc_seq_asserts (.CLK_SYS(CLK_SYS),
   .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .SAMPLE_HOLD(SAMPLE_HOLD),
   .CONV_ACTIVE(CONV_ACTIVE), .CONV_CHANNEL(CONV_CHANNEL), .CONV_DIFF(CONV_DIFF), .IRQ(IRQ));
